// file: rtl/pmc_pkg.sv
// constants and types for the performance monitor counters
// Notes on behaviour
// - counter width 32, 48 or 64 bits; event and latency counts are parameters
// - defaults: 32-bit counters, five event counters then one latency counter
// - an event counter adds one per selected event while counting runs
// - latency counter keeps count, sum, sum of squares, minimum and maximum in cycles
// - counting starts or stops by debug command or by cross-trigger inputs
// - counters accessed in sequence; selection advances after each access and holds at the last
// - sample command captures all status and values in one cycle
// - event counter at maximum sets its overflow flag and raises interrupt
// - interrupt stays high until a clear command, then returns to zero
// - event 0 instruction, 30 cycle, 10 icache request, 11 icache hit
// - events 12..15 dcache read/hit/write/hit; 46, 47 combined request and hit
// - events 37, 38, 39 branches with delay slot
// - event 43 mmu data request; 48, 49, 50 mmu exceptions
// - monitor present only when debug level parameter equals 2
// - registers reached only through the debug port, serial or parallel
// - command bit 4 clear, 3 start, 2 stop, 1 sample, 0 selection reset
// - status bit 1 overflow, bit 0 latency restart before finish
// - 32-bit latency items: count, sum, square sum, min in 31:16 max in 15:0
// - 8-bit event select written per counter, selection advances per write up to the last counter
package pmc_pkg;
   localparam int PMC_DBG_EXTENDED = 2;
   localparam int PMC_DEF_WIDTH = 32;
   localparam int PMC_DEF_EVENTS = 5;
   localparam int PMC_DEF_LATENCY = 1;
   localparam int PMC_LAT_ITEMS32 = 4;
   localparam int PMC_LAT_ITEMS_WIDE = 7;

   // register addresses on the debug port
   localparam logic [2:0] PMC_ADDR_EVSEL = 3'h1;
   localparam logic [2:0] PMC_ADDR_CMD = 3'h2;
   localparam logic [2:0] PMC_ADDR_STATE = 3'h3;
   localparam logic [2:0] PMC_ADDR_DREAD = 3'h6;
   localparam logic [2:0] PMC_ADDR_DWRITE = 3'h7;

   localparam int PMC_CMD_CLEAR = 4;
   localparam int PMC_CMD_START = 3;
   localparam int PMC_CMD_STOP = 2;
   localparam int PMC_CMD_SAMPLE = 1;
   localparam int PMC_CMD_SELRST = 0;
   localparam int PMC_ST_OVF = 1;
   localparam int PMC_ST_FULL = 0;

   localparam logic [7:0] PMC_EV_INSTR = 8'h00;
   localparam logic [7:0] PMC_EV_IC_REQ = 8'h0a;
   localparam logic [7:0] PMC_EV_IC_HIT = 8'h0b;
   localparam logic [7:0] PMC_EV_DC_RD = 8'h0c;
   localparam logic [7:0] PMC_EV_DC_RDHIT = 8'h0d;
   localparam logic [7:0] PMC_EV_DC_WR = 8'h0e;
   localparam logic [7:0] PMC_EV_DC_WRHIT = 8'h0f;
   localparam logic [7:0] PMC_EV_CYCLE = 8'h1e;
   localparam logic [7:0] PMC_EV_BR_DS = 8'h25;
   localparam logic [7:0] PMC_EV_BRT_DS = 8'h26;
   localparam logic [7:0] PMC_EV_BRN_DS = 8'h27;
   localparam logic [7:0] PMC_EV_MMU_DREQ = 8'h2b;
   localparam logic [7:0] PMC_EV_DC_REQ = 8'h2e;
   localparam logic [7:0] PMC_EV_DC_HIT = 8'h2f;
   localparam logic [7:0] PMC_EV_MMU_EXC = 8'h30;
   localparam logic [7:0] PMC_EV_MMU_IEXC = 8'h31;
   localparam logic [7:0] PMC_EV_MMU_DEXC = 8'h32;
   localparam logic [7:0] PMC_EVSEL_RST = 8'h00;

   // processor pipeline event strobes
   typedef struct packed {
      logic instr_valid;
      logic icache_req;
      logic icache_hit;
      logic dcache_rd;
      logic dcache_rd_hit;
      logic dcache_wr;
      logic dcache_wr_hit;
      logic br_uncond_ds;
      logic br_taken_ds;
      logic br_ntaken_ds;
      logic mmu_data_req;
      logic mmu_iexc;
      logic mmu_dexc;
   } pmc_events_type;

   // debug register port command
   typedef struct packed {
      logic [2:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } pmc_dbg_req_type;

   typedef enum logic [2:0] {
      PMC_ST_IDLE = 3'b001,
      PMC_ST_RUN = 3'b010,
      PMC_ST_BUSY = 3'b100
   } pmc_lat_state_type;
endpackage

// file: rtl/pmc_snap_mem.sv
// sampled counter item memory with registered read
`timescale 1ns/1ps
module pmc_snap_mem
   import pmc_pkg::*;
#(
   parameter int WIDTH = 32,
   parameter int DEPTH = 9,
   parameter int AW = 4
)
(
   input wire logic clk,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [WIDTH-1:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [WIDTH-1:0] rdata
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clk)
   begin
      if (we)
      begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule // pmc_snap_mem

// file: rtl/pmc_perf_monitor.sv
// performance monitor: event counters, latency counter and debug registers
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module pmc_perf_monitor
   import pmc_pkg::*;
#(
   parameter int DEBUG_LEVEL = PMC_DBG_EXTENDED,
   parameter int CNT_WIDTH = PMC_DEF_WIDTH,
   parameter int NUM_EVENTS = PMC_DEF_EVENTS,
   parameter int NUM_LATENCY = PMC_DEF_LATENCY
)
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire pmc_dbg_req_type dbg_req,
   output logic [31:0] dbg_rdata,
   input wire pmc_events_type events,
   input wire logic lat_start,
   input wire logic lat_finish,
   input wire logic xtrig_start,
   input wire logic xtrig_stop,
   output logic perf_intr
);
   ////////////////////////////////////////////////////////////////////////////
   localparam int NCNT = NUM_EVENTS + NUM_LATENCY;
   localparam int LAT_ITEMS = (CNT_WIDTH == 32) ? PMC_LAT_ITEMS32 : PMC_LAT_ITEMS_WIDE;
   localparam int EV_ITEMS = (CNT_WIDTH == 32) ? 1 : 2;
   localparam int NITEMS = NUM_EVENTS * EV_ITEMS + NUM_LATENCY * LAT_ITEMS;
   localparam int IW = $clog2(NITEMS + 1);
   localparam int SW = $clog2(NCNT + 1);
   localparam int MW = (CNT_WIDTH == 32) ? 16 : 32;
   localparam logic [CNT_WIDTH-1:0] CMAX = '1;
   localparam logic [MW-1:0] MMAX = '1;
   localparam bit PRESENT = (DEBUG_LEVEL == PMC_DBG_EXTENDED);

   // event number to strobe, used for every event counter
   function automatic logic ev_hit(input logic [7:0] sel, input pmc_events_type e);
      logic h;
      h = 1'b0;
      case (sel)
         PMC_EV_INSTR: h = e.instr_valid;
         PMC_EV_CYCLE: h = 1'b1;
         PMC_EV_IC_REQ: h = e.icache_req;
         PMC_EV_IC_HIT: h = e.icache_hit;
         PMC_EV_DC_RD: h = e.dcache_rd;
         PMC_EV_DC_RDHIT: h = e.dcache_rd_hit;
         PMC_EV_DC_WR: h = e.dcache_wr;
         PMC_EV_DC_WRHIT: h = e.dcache_wr_hit;
         PMC_EV_DC_REQ: h = e.dcache_rd | e.dcache_wr;
         PMC_EV_DC_HIT: h = e.dcache_rd_hit | e.dcache_wr_hit;
         PMC_EV_BR_DS: h = e.br_uncond_ds;
         PMC_EV_BRT_DS: h = e.br_taken_ds;
         PMC_EV_BRN_DS: h = e.br_ntaken_ds;
         PMC_EV_MMU_DREQ: h = e.mmu_data_req;
         PMC_EV_MMU_EXC: h = e.mmu_iexc | e.mmu_dexc;
         PMC_EV_MMU_IEXC: h = e.mmu_iexc;
         PMC_EV_MMU_DEXC: h = e.mmu_dexc;
         default: h = 1'b0;
      endcase
      return h;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // debug port decode; registers invisible elsewhere
   wire logic wr_evsel = PRESENT && dbg_req.wr && dbg_req.addr == PMC_ADDR_EVSEL;
   wire logic wr_cmd = PRESENT && dbg_req.wr && dbg_req.addr == PMC_ADDR_CMD;
   wire logic rd_state = PRESENT && dbg_req.rd && dbg_req.addr == PMC_ADDR_STATE;
   wire logic rd_data = PRESENT && dbg_req.rd && dbg_req.addr == PMC_ADDR_DREAD;
   wire logic wr_data = PRESENT && dbg_req.wr && dbg_req.addr == PMC_ADDR_DWRITE;
   wire logic cmd_clear = wr_cmd & dbg_req.wdata[PMC_CMD_CLEAR];
   wire logic cmd_start = wr_cmd & dbg_req.wdata[PMC_CMD_START];
   wire logic cmd_stop = wr_cmd & dbg_req.wdata[PMC_CMD_STOP];
   wire logic cmd_sample = wr_cmd & dbg_req.wdata[PMC_CMD_SAMPLE];
   wire logic cmd_selrst = wr_cmd & dbg_req.wdata[PMC_CMD_SELRST];

   logic [IW-1:0] item_ff;
   logic [SW-1:0] sel_ff;
   logic run_ff;
   logic [7:0] evsel_ff [NCNT];
   logic [CNT_WIDTH-1:0] ecnt_ff [NUM_EVENTS];
   logic [1:0] est_ff [NUM_EVENTS];
   logic [1:0] snap_st_ff [NCNT];
   logic [NUM_EVENTS-1:0] ev_ovf;

   // sync cross-trigger pins
   logic [1:0] xs_ff;
   logic [1:0] xp_ff;
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         xs_ff <= 2'h0;
         xp_ff <= 2'h0;
      end
      else
      begin
         xs_ff <= {xs_ff[0], xtrig_start};
         xp_ff <= {xp_ff[0], xtrig_stop};
      end
   end

   // stop wins over start when both arrive together
   wire logic go = cmd_start | xs_ff[1];
   wire logic halt = cmd_stop | xp_ff[1];
   wire logic nxt_run = halt ? 1'b0 : (go ? 1'b1 : run_ff);

   // one access pointer for status/select, one for data items
   wire logic sel_step = wr_evsel | rd_state;
   wire logic item_step = rd_data | wr_data;
   wire logic [SW-1:0] nxt_sel = cmd_selrst ? '0 : sel_ff + SW'(sel_step && sel_ff < SW'(NCNT - 1));
   wire logic [IW-1:0] nxt_item = cmd_selrst ? '0 : item_ff + IW'(item_step && item_ff < IW'(NITEMS - 1));

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         run_ff <= 1'b0;
         sel_ff <= '0;
         item_ff <= '0;
      end
      else
      begin
         run_ff <= nxt_run;
         sel_ff <= nxt_sel;
         item_ff <= nxt_item;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // event select registers and event counters
   genvar gi;
   generate
      for (gi = 0; gi < NCNT; gi++)
      begin : g_sel
         always_ff @(posedge clk or posedge sys_rst)
         begin
            if (sys_rst)
               evsel_ff[gi] <= PMC_EVSEL_RST;
            else if (wr_evsel && sel_ff == SW'(gi))
               evsel_ff[gi] <= dbg_req.wdata[7:0];
         end
      end
      for (gi = 0; gi < NUM_EVENTS; gi++)
      begin : g_ev
         localparam int LO = (CNT_WIDTH == 32) ? gi : 2 * gi;
         wire logic hit = run_ff & ev_hit(evsel_ff[gi], events);
         wire logic at_max = ecnt_ff[gi] == CMAX;
         wire logic wr_lo = wr_data && item_ff == IW'(LO + EV_ITEMS - 1);
         wire logic wr_hi = wr_data && EV_ITEMS == 2 && item_ff == IW'(LO);
         wire logic [CNT_WIDTH+31:0] hi_load = {dbg_req.wdata, ecnt_ff[gi][31:0]};
         assign ev_ovf[gi] = est_ff[gi][PMC_ST_OVF];
         always_ff @(posedge clk or posedge sys_rst)
         begin
            if (sys_rst)
            begin
               ecnt_ff[gi] <= '0;
               est_ff[gi] <= 2'h0;
            end
            else if (cmd_clear)
            begin
               ecnt_ff[gi] <= '0;
               est_ff[gi] <= 2'h0;
            end
            else
            begin
               if (wr_lo)
                  ecnt_ff[gi][31:0] <= dbg_req.wdata;
               else if (wr_hi)
                  ecnt_ff[gi] <= hi_load[CNT_WIDTH-1:0];
               else if (hit)
                  ecnt_ff[gi] <= ecnt_ff[gi] + 1'b1;
               if (hit && at_max)
                  est_ff[gi][PMC_ST_OVF] <= 1'b1;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // latency counter (first one is measured; extra ones read as zero)
   pmc_lat_state_type lst_ff;
   logic [MW-1:0] lcur_ff;
   logic [CNT_WIDTH-1:0] ln_ff;
   logic [CNT_WIDTH-1:0] lsum_ff;
   logic [CNT_WIDTH-1:0] lsq_ff;
   logic [MW-1:0] lmin_ff;
   logic [MW-1:0] lmax_ff;
   logic [1:0] lat_st_ff;
   wire logic lat_done = run_ff && lst_ff == PMC_ST_RUN && lat_finish;
   wire logic [MW-1:0] lat_val = lcur_ff + 1'b1;
   wire logic [CNT_WIDTH-1:0] lat_sq = CNT_WIDTH'(lat_val) * CNT_WIDTH'(lat_val);
   wire pmc_lat_state_type nxt_lst = !run_ff ? PMC_ST_IDLE :
      (lat_start ? PMC_ST_RUN : (lat_finish ? PMC_ST_IDLE : lst_ff));

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         lst_ff <= PMC_ST_IDLE;
         lcur_ff <= '0;
         ln_ff <= '0;
         lsum_ff <= '0;
         lsq_ff <= '0;
         lmin_ff <= MMAX;
         lmax_ff <= '0;
         lat_st_ff <= 2'h0;
      end
      else if (cmd_clear)
      begin
         lst_ff <= PMC_ST_IDLE;
         lcur_ff <= '0;
         ln_ff <= '0;
         lsum_ff <= '0;
         lsq_ff <= '0;
         lmin_ff <= MMAX;
         lmax_ff <= '0;
         lat_st_ff <= 2'h0;
      end
      else
      begin
         lst_ff <= nxt_lst;
         case (lst_ff)
            PMC_ST_IDLE: lcur_ff <= '0;
            PMC_ST_RUN: lcur_ff <= (lat_start || lat_finish) ? '0 : lat_val;
            PMC_ST_BUSY: lcur_ff <= '0;
            default: lcur_ff <= '0;
         endcase
         if (run_ff && lst_ff == PMC_ST_RUN && lat_start && !lat_finish)
            lat_st_ff[PMC_ST_FULL] <= 1'b1;
         if (lat_done)
         begin
            ln_ff <= ln_ff + 1'b1;
            lsum_ff <= lsum_ff + CNT_WIDTH'(lat_val);
            lsq_ff <= lsq_ff + lat_sq;
            if (lat_val < lmin_ff)
               lmin_ff <= lat_val;
            if (lat_val > lmax_ff)
               lmax_ff <= lat_val;
            if (ln_ff == CMAX || lsum_ff > CMAX - CNT_WIDTH'(lat_val))
               lat_st_ff[PMC_ST_OVF] <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // item list in access order: events, then latency items
   logic [31:0] items [NITEMS];
   generate
      for (gi = 0; gi < NUM_EVENTS; gi++)
      begin : g_evi
         if (CNT_WIDTH == 32)
         begin : g_n
            assign items[gi] = ecnt_ff[gi];
         end
         else
         begin : g_w
            assign items[2*gi] = 32'(ecnt_ff[gi][CNT_WIDTH-1:32]);
            assign items[2*gi+1] = ecnt_ff[gi][31:0];
         end
      end
      for (gi = 0; gi < NUM_LATENCY; gi++)
      begin : g_lti
         localparam int B = NUM_EVENTS * EV_ITEMS + gi * LAT_ITEMS;
         if (CNT_WIDTH == 32)
         begin : g_n
            assign items[B] = (gi == 0) ? ln_ff : 32'h0;
            assign items[B+1] = (gi == 0) ? lsum_ff : 32'h0;
            assign items[B+2] = (gi == 0) ? lsq_ff : 32'h0;
            assign items[B+3] = (gi == 0) ? {lmin_ff, lmax_ff} : 32'h0;
         end
         else
         begin : g_w
            assign items[B] = (gi == 0) ? ln_ff[31:0] : 32'h0;
            assign items[B+1] = (gi == 0) ? 32'(lsum_ff[CNT_WIDTH-1:32]) : 32'h0;
            assign items[B+2] = (gi == 0) ? lsum_ff[31:0] : 32'h0;
            assign items[B+3] = (gi == 0) ? 32'(lsq_ff[CNT_WIDTH-1:32]) : 32'h0;
            assign items[B+4] = (gi == 0) ? lsq_ff[31:0] : 32'h0;
            assign items[B+5] = (gi == 0) ? 32'(lmin_ff) : 32'h0;
            assign items[B+6] = (gi == 0) ? 32'(lmax_ff) : 32'h0;
         end
      end
      for (gi = 0; gi < NCNT; gi++)
      begin : g_sst
         wire logic [1:0] live = (gi < NUM_EVENTS) ? est_ff[gi % NUM_EVENTS] : ((gi == NUM_EVENTS) ? lat_st_ff : 2'h0);
         always_ff @(posedge clk or posedge sys_rst)
         begin
            if (sys_rst)
               snap_st_ff[gi] <= 2'h0;
            else if (cmd_sample)
               snap_st_ff[gi] <= live;
         end
      end
   endgenerate

   // sample copies all items into memory over following cycles; status is exact
   logic [IW-1:0] cp_ff;
   logic cp_busy_ff;
   logic [31:0] snap_rdata;
   logic [31:0] items_frozen [NITEMS];
   generate
      for (gi = 0; gi < NITEMS; gi++)
      begin : g_frz
         always_ff @(posedge clk)
         begin
            if (cmd_sample)
               items_frozen[gi] <= items[gi];
         end
      end
   endgenerate

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cp_ff <= '0;
         cp_busy_ff <= 1'b0;
      end
      else
      begin
         if (cmd_sample)
         begin
            cp_ff <= '0;
            cp_busy_ff <= 1'b1;
         end
         else if (cp_busy_ff)
         begin
            // pointer parks on the last item so the frozen copy is never indexed past its end
            cp_busy_ff <= cp_ff != IW'(NITEMS - 1);
            cp_ff <= (cp_ff == IW'(NITEMS - 1)) ? cp_ff : cp_ff + 1'b1;
         end
      end
   end

   pmc_snap_mem #(.WIDTH(32), .DEPTH(NITEMS), .AW(IW)) u_snap
   (
      .clk(clk),
      .we(cp_busy_ff),
      .waddr(cp_ff),
      .wdata(items_frozen[cp_ff]),
      .raddr(item_ff),
      .rdata(snap_rdata)
   );

   ////////////////////////////////////////////////////////////////////////////
   // read answer and interrupt
   logic rd_state_ff;
   logic rd_data_ff;
   logic [1:0] st_rd_ff;
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rd_state_ff <= 1'b0;
         rd_data_ff <= 1'b0;
         st_rd_ff <= 2'h0;
         perf_intr <= 1'b0;
      end
      else
      begin
         rd_state_ff <= rd_state;
         rd_data_ff <= rd_data;
         st_rd_ff <= snap_st_ff[sel_ff];
         // clear wins: a fresh overflow in the clear cycle is already zeroed by clear
         perf_intr <= PRESENT && !cmd_clear && ((|ev_ovf) || perf_intr);
      end
   end
   // data comes straight from the memory register or the status register
   assign dbg_rdata = rd_data_ff ? snap_rdata : (rd_state_ff ? {30'h0, st_rd_ff} : 32'h0);
endmodule // pmc_perf_monitor

// file: sim/pmc_perf_monitor_asserts.sv
// port assertions for the performance monitor
`timescale 1ns/1ps
module pmc_perf_monitor_asserts
   import pmc_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire pmc_dbg_req_type dbg_req,
   input wire logic [31:0] dbg_rdata,
   input wire pmc_events_type events,
   input wire logic lat_start,
   input wire logic lat_finish,
   input wire logic xtrig_start,
   input wire logic xtrig_stop,
   input wire logic perf_intr
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////////////////////////////
   wire logic [2:0] a = dbg_req.addr;
   wire logic clr_cmd = dbg_req.wr && a == PMC_ADDR_CMD && dbg_req.wdata[PMC_CMD_CLEAR];
   wire logic rd_wo = dbg_req.rd && (a == PMC_ADDR_EVSEL || a == PMC_ADDR_CMD || a == PMC_ADDR_DWRITE);
   wire logic rd_unm = dbg_req.rd && (a == 3'h0 || a == 3'h4 || a == 3'h5);
   wire logic rd_st = dbg_req.rd && a == PMC_ADDR_STATE;
   ////////////////////////////////////////////////////////////////
   a_rdata_idle: assert property (!dbg_req.rd |=> dbg_rdata == 32'h0)
      else $error("read data not zero outside answer cycle");
   a_wo_zero: assert property (rd_wo |=> dbg_rdata == 32'h0)
      else $error("write-only register read not zero");
   a_unmapped_zero: assert property (rd_unm |=> dbg_rdata == 32'h0)
      else $error("unmapped read not zero");
   a_state_width: assert property (rd_st |=> dbg_rdata[31:2] == 30'h0)
      else $error("state read has upper bits set");
   a_intr_clear: assert property (clr_cmd |=> !perf_intr)
      else $error("interrupt survives clear");
   a_intr_hold: assert property (perf_intr && !clr_cmd |=> perf_intr)
      else $error("interrupt dropped without clear");
   a_intr_reset: assert property ($fell(sys_rst) |-> !perf_intr)
      else $error("interrupt high after reset");
   a_intr_cause: assert property ($rose(perf_intr) |-> !$past(clr_cmd))
      else $error("interrupt raised right after clear");
   c_intr: cover property ($rose(perf_intr));
   c_full: cover property (rd_st ##1 dbg_rdata[PMC_ST_FULL]);
   c_lat: cover property (lat_start ##[1:8] lat_finish);
endmodule // pmc_perf_monitor_asserts

bind pmc_perf_monitor pmc_perf_monitor_asserts u_chk (.clk(clk), .sys_rst(sys_rst), .dbg_req(dbg_req),
   .dbg_rdata(dbg_rdata), .events(events), .lat_start(lat_start), .lat_finish(lat_finish),
   .xtrig_start(xtrig_start), .xtrig_stop(xtrig_stop), .perf_intr(perf_intr));

// file: sim/pmc_dbg_hub.sv
// debug hub model driving the debug register port
`timescale 1ns/1ps
module pmc_dbg_hub
   import pmc_pkg::*;
(
   input wire logic clk,
   input wire logic [31:0] dbg_rdata,
   output pmc_dbg_req_type dbg_req
);
   initial dbg_req = '0;
   ////////////////////////////////////////////////////////////////
   // released write data flips so a stale value cannot pass
   task automatic wr(input logic [2:0] a, input logic [31:0] d);
      @(posedge clk);
      dbg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      dbg_req.wr <= 1'b0;
      dbg_req.wdata <= ~d;
   endtask
   task automatic rd(input logic [2:0] a, output logic [31:0] d);
      @(posedge clk);
      dbg_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      dbg_req.rd <= 1'b0;
      // answer stands only in the cycle after the strobe; take it at that cycle's closing edge
      @(posedge clk);
      d = dbg_rdata;
   endtask
   task automatic cmd(input logic [4:0] bits);
      wr(PMC_ADDR_CMD, {27'h0, bits});
   endtask
   task automatic sel(input logic [7:0] ev);
      wr(PMC_ADDR_EVSEL, {24'h0, ev});
   endtask
endmodule // pmc_dbg_hub

// file: sim/pmc_perf_monitor_test.sv
// self-checking bench for the performance monitor
`timescale 1ns/1ps
module pmc_perf_monitor_test;
   import pmc_pkg::*;
   localparam int NC = 16;
   logic clk = 1'b0;
   logic sys_rst;
   pmc_dbg_req_type dbg_req;
   logic [31:0] dbg_rdata;
   logic [31:0] rd_data;
   pmc_events_type events;
   logic lat_start;
   logic lat_finish;
   logic xtrig_start;
   logic xtrig_stop;
   logic perf_intr;
   int mismatches = 0;
   int checks = 0;
   int cycles = 0;
   logic [7:0] codes [NC] = '{PMC_EV_INSTR, PMC_EV_IC_REQ, PMC_EV_IC_HIT, PMC_EV_DC_RD, PMC_EV_DC_RDHIT,
      PMC_EV_DC_WR, PMC_EV_DC_WRHIT, PMC_EV_BR_DS, PMC_EV_BRT_DS, PMC_EV_BRN_DS, PMC_EV_MMU_DREQ,
      PMC_EV_DC_REQ, PMC_EV_DC_HIT, PMC_EV_MMU_EXC, PMC_EV_MMU_IEXC, PMC_EV_MMU_DEXC};
   logic [12:0] masks [NC] = '{13'h1000, 13'h0800, 13'h0400, 13'h0200, 13'h0100, 13'h0080, 13'h0040,
      13'h0020, 13'h0010, 13'h0008, 13'h0004, 13'h0200, 13'h0100, 13'h0002, 13'h0002, 13'h0001};
   // latency items after runs of 2 and 4 cycles, start edge to finish edge
   logic [31:0] lexp [9] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h2, 32'h6, 32'h14, 32'h00020004};
   always #12.5 clk = ~clk;
   ////////////////////////////////////////////////////////////////
   pmc_perf_monitor dut (.clk(clk), .sys_rst(sys_rst), .dbg_req(dbg_req), .dbg_rdata(dbg_rdata),
      .events(events), .lat_start(lat_start), .lat_finish(lat_finish), .xtrig_start(xtrig_start),
      .xtrig_stop(xtrig_stop), .perf_intr(perf_intr));
   pmc_dbg_hub hub (.clk(clk), .dbg_rdata(dbg_rdata), .dbg_req(dbg_req));
   ////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic final_report();
      $display("checks=%0d mismatches=%0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 6000)
      begin
         mismatches++;
         final_report();
      end
   end
   task automatic pulse(input pmc_events_type m, input int n);
      @(posedge clk);
      events <= m;
      repeat (n) @(posedge clk);
      events <= '0;
   endtask
   // start sampled one edge, finish n-1 edges later
   task automatic lat(input int n);
      @(posedge clk);
      lat_start <= 1'b1;
      @(posedge clk);
      lat_start <= 1'b0;
      repeat (n - 2) @(posedge clk);
      lat_finish <= 1'b1;
      @(posedge clk);
      lat_finish <= 1'b0;
   endtask
   // items are copied after the sample, so wait before rewinding
   task automatic sample(input logic [4:0] c);
      repeat (2) @(posedge clk);
      hub.cmd(c);
      repeat (14) @(posedge clk);
      hub.cmd(5'h01);
   endtask
   task automatic xtrig(input logic go);
      @(posedge clk);
      if (go)
         xtrig_start <= 1'b1;
      else
         xtrig_stop <= 1'b1;
      repeat (4) @(posedge clk);
      xtrig_start <= 1'b0;
      xtrig_stop <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   ////////////////////////////////////////////////////////////////
   initial
   begin
      sys_rst <= 1'b1;
      events <= '0;
      lat_start <= 1'b0;
      lat_finish <= 1'b0;
      xtrig_start <= 1'b0;
      xtrig_stop <= 1'b0;
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < NC; i++)
      begin
         hub.cmd(5'h01);
         hub.sel(codes[i]);
         hub.cmd(5'h18);
         pulse(pmc_events_type'(masks[i]), 4);
         sample(5'h06);
         hub.rd(PMC_ADDR_DREAD, rd_data);
         chk(rd_data, 32'h4);
      end
      hub.cmd(5'h01);
      for (int j = 0; j < 6; j++)
         hub.sel(j < 5 ? PMC_EV_INSTR : 8'h3a);
      hub.cmd(5'h18);
      lat(3);
      lat(5);
      sample(5'h06);
      for (int j = 0; j < 9; j++)
      begin
         hub.rd(PMC_ADDR_DREAD, rd_data);
         chk(rd_data, lexp[j]);
      end
      // second start before finish marks the latency counter full
      hub.cmd(5'h18);
      @(posedge clk);
      lat_start <= 1'b1;
      @(posedge clk);
      lat_start <= 1'b0;
      lat(3);
      sample(5'h06);
      for (int j = 0; j < 6; j++)
      begin
         hub.rd(PMC_ADDR_STATE, rd_data);
         chk(rd_data, j < 5 ? 32'h0 : 32'h1);
      end
      hub.cmd(5'h01);
      hub.sel(PMC_EV_INSTR);
      hub.cmd(5'h18);
      xtrig(1'b0);
      pulse(pmc_events_type'(13'h1000), 4);
      sample(5'h02);
      hub.rd(PMC_ADDR_DREAD, rd_data);
      chk(rd_data, 32'h0);
      xtrig(1'b1);
      pulse(pmc_events_type'(13'h1000), 4);
      sample(5'h06);
      hub.rd(PMC_ADDR_DREAD, rd_data);
      chk(rd_data, 32'h4);
      hub.cmd(5'h01);
      hub.sel(PMC_EV_CYCLE);
      hub.cmd(5'h11);
      hub.wr(PMC_ADDR_DWRITE, 32'hffff_fff0);
      hub.cmd(5'h08);
      repeat (40) @(posedge clk);
      chk({31'h0, perf_intr}, 32'h1);
      sample(5'h06);
      hub.rd(PMC_ADDR_STATE, rd_data);
      chk(rd_data, 32'h2);
      repeat (10) @(posedge clk);
      chk({31'h0, perf_intr}, 32'h1);
      hub.cmd(5'h10);
      @(negedge clk);
      chk({31'h0, perf_intr}, 32'h0);
      hub.rd(PMC_ADDR_CMD, rd_data);
      chk(rd_data, 32'h0);
      hub.rd(3'h4, rd_data);
      chk(rd_data, 32'h0);
      final_report();
   end
endmodule // pmc_perf_monitor_test
